// ==== phy_strap_params.svh ====
// Constants for the strap, indicator and status pin logic.
// Assumes inclusion once per compile unit through its guard.
`ifndef PHY_STRAP_PARAMS_SVH
`define PHY_STRAP_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define REG_CONTROL_OFS 5'h00
`define REG_STATUS_OFS 5'h01
`define REG_SUMMARY_OFS 5'h11
`define REG_IRQ_STATUS_OFS 5'h1a
`define REG_IRQ_MASK_OFS 5'h1b

// ****************************************
// Field positions
// ****************************************
`define CTRL_RATE_BIT 13
`define CTRL_ISOLATE_BIT 10
`define CTRL_SOFT_RESET_BIT 15
`define CTRL_RESET_VAL 16'h0000
`define IRQ_MASK_RESET_VAL 16'h0000
`define STATUS_CAPS_VAL 16'h7809
`define IRQ_LINK_CHANGE_BIT 0
`define IRQ_LOCK_CHANGE_BIT 1
`define IRQ_WIDTH 2
`define ADDR_ZERO 5'h00

`endif

// ==== phy_strap_pkg.sv ====
// Types shared by the strap, indicator and status pin logic.
// Assumes the params header supplies all numeric constants.
package phy_strap_pkg;

  typedef enum logic [1:0] {
    mac_if_mii_10 = 2'b00,
    mac_if_mii_100 = 2'b01,
    mac_if_symbol_100 = 2'b10,
    mac_if_serial_10 = 2'b11
  } mac_if_e;

  typedef enum logic [1:0] {
    st_reset = 2'b00,
    st_run = 2'b01
  } strap_state_e;

  typedef struct packed {
    logic rx_clk;
    logic [3:0] rx_data;
    logic rx_valid;
    logic rx_error;
  } rx_group_s;

  typedef struct packed {
    logic activity;
    logic collision;
    logic link_ok;
    logic tx_data;
    logic rx_data;
  } led_s;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic autoneg;
    logic repeater;
    mac_if_e mac_if;
  } mode_s;

endpackage : phy_strap_pkg

// ==== phy_strap_config_status.sv ====
// Configuration straps, receive isolation, indicator pins and status registers.
// Assumes all inputs are synchronous to clock_in, and that the MII datapath,
// management framing and auto-negotiation live elsewhere.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "phy_strap_params.svh"

module phy_strap_config_status (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic hardware_reset_low_pin_in,
  input wire logic hardware_software_select_pin_in,
  input wire logic speed_select_pin_in,
  input wire logic duplex_select_pin_in,
  input wire logic autoneg_select_pin_in,
  input wire logic node_repeater_pin_in,
  input wire logic mii_serial_select_pin_in,
  input wire logic rx_float_pin_in,
  input wire phy_strap_pkg::rx_group_s rx_group_in,
  input wire logic [4:0] strap_pins_in,
  input wire phy_strap_pkg::led_s led_events_in,
  input wire logic link_up_in,
  input wire logic lock_in,
  input wire logic an_complete_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  output phy_strap_pkg::rx_group_s rx_group_out,
  output logic rx_group_oe_out,
  output logic tx_path_oe_out,
  output logic [4:0] strap_pins_out,
  output logic [4:0] strap_pins_oe_out,
  output logic speed_select_pin_out,
  output logic speed_select_pin_oe_out,
  output logic link_state_out,
  output logic lock_out,
  output phy_strap_pkg::mode_s mode_out,
  output logic [4:0] phy_addr_out,
  output logic soft_reset_out,
  output logic irq_out
);
  import phy_strap_pkg::*;

  // ****************************************
  // State
  // ****************************************
  strap_state_e state_ff;
  strap_state_e nxt_state;
  logic [4:0] addr_ff;
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [`IRQ_WIDTH-1:0] irq_stat_ff;
  logic [`IRQ_WIDTH-1:0] nxt_irq_stat;
  logic [`IRQ_WIDTH-1:0] irq_mask_ff;
  logic link_prev_ff;
  logic lock_prev_ff;
  logic hw_reset_active;

  // Either reset holds the straps as inputs; soft reset does not
  assign hw_reset_active = reset_in | ~hardware_reset_low_pin_in;

  // ****************************************
  // Strap sampling
  // ****************************************
  always_comb begin
    case (state_ff)
      st_reset: nxt_state = hw_reset_active ? st_reset : st_run;
      st_run: nxt_state = hw_reset_active ? st_reset : st_run;
      default: nxt_state = st_reset;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff <= st_reset;
      addr_ff <= `ADDR_ZERO;
    end else if (enable_in) begin
      state_ff <= nxt_state;
      // Pins stay inputs through the exit cycle, so the exit level is the strap
      if (state_ff == st_reset) begin
        addr_ff <= strap_pins_in;
      end
    end
  end

  wire running = (state_ff == st_run) && !hw_reset_active;

  // ****************************************
  // Register bus decode
  // ****************************************
  wire hw_mode = hardware_software_select_pin_in;
  wire wr_ctrl = reg_write_in && reg_addr_in == `REG_CONTROL_OFS;
  wire wr_irq_stat = reg_write_in && reg_addr_in == `REG_IRQ_STATUS_OFS;
  wire wr_irq_mask = reg_write_in && reg_addr_in == `REG_IRQ_MASK_OFS;
  wire rate_bit = ctrl_ff[`CTRL_RATE_BIT];
  wire isolate_bit = ctrl_ff[`CTRL_ISOLATE_BIT];

  // Soft reset bit self-clears so it never alters strap direction
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl[`CTRL_SOFT_RESET_BIT] = 1'b0;
    if (wr_ctrl) begin
      nxt_ctrl = reg_wdata_in;
    end
  end

  wire link_edge = link_up_in ^ link_prev_ff;
  wire lock_edge = lock_in ^ lock_prev_ff;
  wire [`IRQ_WIDTH-1:0] irq_set = {lock_edge, link_edge};
  wire [`IRQ_WIDTH-1:0] irq_clr = wr_irq_stat ? reg_wdata_in[`IRQ_WIDTH-1:0] : '0;

  // Set beats clear in the same cycle so no event is lost
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

  wire [15:0] summary_word = {8'h00, 1'b0, an_complete_in, lock_in,
    link_up_in, mode_out.speed_100, mode_out.full_duplex, 2'b00};
  wire [15:0] status_word = `STATUS_CAPS_VAL
    | {10'h000, an_complete_in, 2'b00, link_up_in, 2'b00};

  logic [15:0] rdata_sel;
  always_comb begin
    case (reg_addr_in)
      `REG_CONTROL_OFS: rdata_sel = ctrl_ff;
      `REG_STATUS_OFS: rdata_sel = status_word;
      `REG_SUMMARY_OFS: rdata_sel = summary_word;
      `REG_IRQ_STATUS_OFS: rdata_sel = {14'h0, irq_stat_ff};
      `REG_IRQ_MASK_OFS: rdata_sel = {14'h0, irq_mask_ff};
      default: rdata_sel = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_ff <= `CTRL_RESET_VAL;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      link_prev_ff <= 1'b0;
      lock_prev_ff <= 1'b0;
      reg_rdata_out <= 16'h0000;
      irq_out <= 1'b0;
      soft_reset_out <= 1'b0;
    end else if (enable_in) begin
      ctrl_ff <= nxt_ctrl;
      irq_stat_ff <= nxt_irq_stat;
      if (wr_irq_mask) begin
        irq_mask_ff <= reg_wdata_in[`IRQ_WIDTH-1:0];
      end
      link_prev_ff <= link_up_in;
      lock_prev_ff <= lock_in;
      reg_rdata_out <= reg_read_in ? rdata_sel : 16'h0000;
      irq_out <= |(nxt_irq_stat & irq_mask_ff);
      soft_reset_out <= nxt_ctrl[`CTRL_SOFT_RESET_BIT];
    end
  end

  // ****************************************
  // Mode selection and MII output gating
  // ****************************************
  // Hardware mode: straps alone; software mode: control register rate
  wire speed_sel = hw_mode ? speed_select_pin_in : rate_bit;
  wire [1:0] if_code = {mii_serial_select_pin_in, speed_sel};
  wire addr_zero = addr_ff == `ADDR_ZERO;
  // Float pin gates receive group regardless of interface code
  wire rx_float = rx_float_pin_in | isolate_bit | addr_zero;
  wire tx_float = isolate_bit | addr_zero;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mode_out <= '0;
      rx_group_out <= '0;
      rx_group_oe_out <= 1'b0;
      tx_path_oe_out <= 1'b0;
      phy_addr_out <= `ADDR_ZERO;
      link_state_out <= 1'b0;
      lock_out <= 1'b0;
      speed_select_pin_out <= 1'b0;
      speed_select_pin_oe_out <= 1'b0;
      strap_pins_out <= '0;
      strap_pins_oe_out <= '0;
    end else if (enable_in) begin
      mode_out.speed_100 <= speed_sel;
      mode_out.full_duplex <= duplex_select_pin_in;
      mode_out.autoneg <= autoneg_select_pin_in;
      mode_out.repeater <= node_repeater_pin_in;
      mode_out.mac_if <= mac_if_e'(if_code);
      // Receive clock passes through at whatever MII rate the datapath runs
      rx_group_out <= rx_float ? '0 : rx_group_in;
      rx_group_oe_out <= !rx_float;
      tx_path_oe_out <= !tx_float;
      phy_addr_out <= addr_ff;
      link_state_out <= link_up_in;
      lock_out <= lock_in;
      speed_select_pin_out <= rate_bit;
      speed_select_pin_oe_out <= !hw_mode;
      // Order: activity, collision, link, tx, rx on bits 0..4
      strap_pins_oe_out <= running ? 5'h1f : 5'h00;
      for (int i = 0; i < 5; i++) begin
        // Idle level equals strap so indicator stays dark
        strap_pins_out[i] <= running ? (addr_ff[i] ^ led_events_in[4-i])
                                     : addr_ff[i];
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_rx_float_pin: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && rx_float_pin_in |=> !rx_group_oe_out)
    else $error("Receive group driven while float pin high");
  a_isolate_tx: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && isolate_bit |=> !tx_path_oe_out && !rx_group_oe_out)
    else $error("Isolate left a path driven");
  a_strap_dir: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && hw_reset_active |=> strap_pins_oe_out == 5'h00)
    else $error("Strap pins driven during reset");
  a_soft_keep: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && running && !hw_reset_active && $stable(running)
    |=> $stable(addr_ff))
    else $error("Address changed outside hardware reset");
  a_led_invert: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && running && led_events_in[4] |=> strap_pins_out[0] == !addr_ff[0])
    else $error("Activity indicator not inverted");
  a_addr_zero: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && addr_zero |=> !rx_group_oe_out && !tx_path_oe_out)
    else $error("Address zero left MII driven");
  a_link_lock: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in |=> link_state_out == $past(link_up_in) && lock_out == $past(lock_in))
    else $error("Link or lock output wrong");
  a_led_dark: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && !running |=> strap_pins_out == $past(addr_ff))
    else $error("Indicator lit before sampling");
  a_speed_pin: assert property (@(posedge clock_in) disable iff (reset_in)
    enable_in && !hw_mode |=> speed_select_pin_oe_out && speed_select_pin_out == $past(rate_bit))
    else $error("Speed pin not showing rate bit");
  c_float: cover property (@(posedge clock_in) rx_float_pin_in ##1 !rx_group_oe_out);
  c_sample: cover property (@(posedge clock_in) state_ff == st_reset ##1 state_ff == st_run);
  c_irq: cover property (@(posedge clock_in) irq_out);

endmodule : phy_strap_config_status

// ==== phy_board_model.sv ====
// Board model of the five strap and indicator pins with their resistors.
// Assumes the device drives a pin only while its output enable is high.
`timescale 1ns/10ps

module phy_board_model (
  input wire logic [4:0] pull_levels_in,
  input wire logic [4:0] pin_drive_in,
  input wire logic [4:0] pin_oe_in,
  output logic [4:0] pin_level_out
);
  // ****************************************
  // Pin resolution
  // ****************************************
  // A released pin never floats: its resistor always sets the level
  assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & pull_levels_in);
endmodule : phy_board_model

// ==== tb.sv ====
// Self-checking bench for the strap, indicator and status pin logic.
// Assumes registered outputs with one cycle of latency after each input change.
`timescale 1ns/10ps

module tb;
  import phy_strap_pkg::*;
  logic clock_in = 0;
  logic reset_in = 1;
  logic hw_rst_n = 0, hw_mode = 1, spd = 1, dpx = 0, an_sel = 1, rep = 1, ser = 0, flt = 0;
  logic link = 0, lock = 0, an_done = 0, wr = 0, rd = 0, en = 1;
  logic [4:0] addr = 5'h00, pulls = 5'h15, pins_in, pins_out, pins_oe, phy_addr;
  logic [15:0] wdata = 16'h0000, rdata, rdat;
  rx_group_s rx_in = 7'h5b;
  rx_group_s rx_out;
  led_s ev = 5'h00;
  mode_s mode;
  logic rx_oe, tx_oe, spd_out, spd_oe, link_out, lock_out, soft_rst, irq;
  int errors = 0;
  int samples_checked = 0;

  always #50 clock_in = ~clock_in;

  phy_board_model i_phy_board_model (.pull_levels_in(pulls), .pin_drive_in(pins_out),
    .pin_oe_in(pins_oe), .pin_level_out(pins_in));

  phy_strap_config_status i_phy_strap_config_status (.clock_in(clock_in),
    .reset_in(reset_in), .enable_in(en), .hardware_reset_low_pin_in(hw_rst_n),
    .hardware_software_select_pin_in(hw_mode), .speed_select_pin_in(spd),
    .duplex_select_pin_in(dpx), .autoneg_select_pin_in(an_sel),
    .node_repeater_pin_in(rep), .mii_serial_select_pin_in(ser), .rx_float_pin_in(flt),
    .rx_group_in(rx_in), .strap_pins_in(pins_in), .led_events_in(ev),
    .link_up_in(link), .lock_in(lock), .an_complete_in(an_done), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
    .rx_group_out(rx_out), .rx_group_oe_out(rx_oe), .tx_path_oe_out(tx_oe),
    .strap_pins_out(pins_out), .strap_pins_oe_out(pins_oe),
    .speed_select_pin_out(spd_out), .speed_select_pin_oe_out(spd_oe),
    .link_state_out(link_out), .lock_out(lock_out), .mode_out(mode),
    .phy_addr_out(phy_addr), .soft_reset_out(soft_rst), .irq_out(irq));

  // ****************************************
  // Shared tasks
  // ****************************************
  task complete_run;
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick

  task reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clock_in);
    wr <= 0;
    #1;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task reg_rd(input logic [4:0] a);
    @(posedge clock_in);
    addr <= a;
    rd <= 1;
    @(posedge clock_in);
    rd <= 0;
    #1 rdat = rdata;
  endtask : reg_rd

  task wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 20) begin
      tick(1);
      n++;
    end
    check("irq", {15'h0, lvl}, {15'h0, irq});
    if (irq !== lvl) complete_run;
  endtask : wait_irq

  // ****************************************
  // Scenarios
  // ****************************************
  task sc_straps;
    check("addr", 16'h0015, {11'h0, phy_addr});
    check("pin_oe", 16'h001f, {11'h0, pins_oe});
    check("leds_off", 16'h0015, {11'h0, pins_out});
    check("mode", 16'h002d, {10'h0, mode});
  endtask : sc_straps

  // Activity sits at the top of the event struct but at pin 0
  task sc_leds;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_in) ev <= 5'h10 >> i;
      tick(2);
      check("led", {11'h0, 5'h15 ^ (5'h01 << i)}, {11'h0, pins_out});
    end
    @(posedge clock_in) ev <= 5'h00;
  endtask : sc_leds

  task sc_float;
    for (int m = 0; m < 4; m++) begin
      @(posedge clock_in);
      ser <= m[1];
      spd <= m[0];
      flt <= 1;
      tick(2);
      check("rx_oe", 16'h0000, {15'h0, rx_oe});
      check("rx_out", 16'h0000, {9'h0, rx_out});
      check("mac_if", m[15:0], {14'h0, mode.mac_if});
      @(posedge clock_in) flt <= 0;
      tick(2);
      check("rx_pass", {9'h0, rx_in}, {9'h0, rx_out});
      check("rx_oe_on", 16'h0001, {15'h0, rx_oe});
    end
    @(posedge clock_in);
    spd <= 1;
    ser <= 0;
  endtask : sc_float

  task sc_isolate;
    reg_wr(5'h00, 16'h0400);
    tick(2);
    check("iso_rx", 16'h0000, {15'h0, rx_oe});
    check("iso_tx", 16'h0000, {15'h0, tx_oe});
    reg_wr(5'h00, 16'h0000);
    tick(2);
    check("tx_on", 16'h0001, {15'h0, tx_oe});
  endtask : sc_isolate

  task sc_soft;
    int n;
    n = 0;
    reg_wr(5'h00, 16'h8000);
    for (int k = 0; k < 4; k++) begin
      if (soft_rst === 1'b1) n++;
      check("oe_soft", 16'h001f, {11'h0, pins_oe});
      tick(1);
    end
    check("soft_pulse", 16'h0001, n[15:0]);
    check("addr_soft", 16'h0015, {11'h0, phy_addr});
  endtask : sc_soft

  task sc_status;
    @(posedge clock_in);
    link <= 1;
    lock <= 1;
    an_done <= 1;
    dpx <= 1;
    tick(2);
    check("link", 16'h0001, {15'h0, link_out});
    check("lock", 16'h0001, {15'h0, lock_out});
    reg_rd(5'h11);
    check("summary", 16'h007c, rdat);
    reg_rd(5'h01);
    check("status", 16'h782d, rdat);
    reg_rd(5'h05);
    check("unmapped", 16'h0000, rdat);
    @(posedge clock_in) link <= 0;
    tick(2);
    check("link_low", 16'h0000, {15'h0, link_out});
  endtask : sc_status

  // Masked events must stay silent until the mask opens
  task sc_irq;
    check("irq_masked", 16'h0000, {15'h0, irq});
    reg_rd(5'h1a);
    check("irq_stat", 16'h0003, rdat);
    reg_wr(5'h1b, 16'h0001);
    wait_irq(1'b1);
    reg_wr(5'h1a, 16'h0003);
    wait_irq(1'b0);
    reg_rd(5'h1a);
    check("irq_clr", 16'h0000, rdat);
  endtask : sc_irq

  task sc_sw_mode;
    @(posedge clock_in) hw_mode <= 0;
    reg_wr(5'h00, 16'h2000);
    tick(2);
    check("spd_oe", 16'h0001, {15'h0, spd_oe});
    check("spd_hi", 16'h0001, {15'h0, spd_out});
    reg_wr(5'h00, 16'h0000);
    tick(2);
    check("spd_lo", 16'h0000, {15'h0, spd_out});
    @(posedge clock_in) hw_mode <= 1;
  endtask : sc_sw_mode

  task sc_addr_zero;
    @(posedge clock_in);
    pulls <= 5'h00;
    hw_rst_n <= 0;
    tick(3);
    check("oe_in_rst", 16'h0000, {11'h0, pins_oe});
    @(posedge clock_in) hw_rst_n <= 1;
    tick(4);
    check("addr0", 16'h0000, {11'h0, phy_addr});
    check("tx_oe0", 16'h0000, {15'h0, tx_oe});
    check("rx_oe0", 16'h0000, {15'h0, rx_oe});
  endtask : sc_addr_zero

  // Clock enable low must freeze the registered copies
  task sc_enable;
    @(posedge clock_in);
    en <= 0;
    link <= 1;
    tick(2);
    check("link_frozen", 16'h0000, {15'h0, link_out});
    @(posedge clock_in) en <= 1;
    tick(2);
    check("link_thaw", 16'h0001, {15'h0, link_out});
  endtask : sc_enable

  initial begin
    repeat (8) @(posedge clock_in);
    reset_in <= 0;
    hw_rst_n <= 1;
    tick(4);
    sc_straps;
    sc_leds;
    sc_float;
    sc_isolate;
    sc_soft;
    sc_status;
    sc_irq;
    sc_sw_mode;
    sc_addr_zero;
    sc_enable;
    complete_run;
  end
endmodule : tb
